/* sqp_pkg.sv */
// sqp_pkg: constants for the switch forwarding-policy block.
// assumes a 32-bit avalon-mm slave with word addressing.
package sqp_pkg;
  // word indices of the registers (byte address is four times these)
  localparam logic [3:0] SQP_A_SCHED = 4'h0;
  localparam logic [3:0] SQP_A_PRIO = 4'h1;
  localparam logic [3:0] SQP_A_RSV = 4'h2;
  localparam logic [3:0] SQP_A_MCAP = 4'h3;
  localparam logic [3:0] SQP_A_LTHR = 4'h4;
  localparam logic [3:0] SQP_A_STAT = 4'h5;
  localparam logic [3:0] SQP_A_PORT0 = 4'h6;
  // tx_schedule_control fields
  localparam int SQP_B_WLO = 0;
  localparam int SQP_B_WHI = 3;
  localparam int SQP_B_QOS = 5;
  localparam int SQP_B_FCDIS = 6;
  localparam int SQP_B_HDXQ = 7;
  // port_control_one fields
  localparam int SQP_B_FCEN = 0;
  localparam int SQP_B_HDX = 1;
  localparam int SQP_B_VLO = 4;
  localparam int SQP_B_VHI = 6;
  // geometry
  localparam int SQP_NPORT = 9;
  localparam int SQP_NPRI = 4;
  localparam int SQP_CW = 9;
  localparam logic [8:0] SQP_CAP_SMALL = 9'h0AA;
  localparam logic [8:0] SQP_CAP_BIG = 9'h154;
  // reset values, then the two trunk member port numbers
  localparam logic [7:0] SQP_R_SCHED = 8'h04;
  localparam logic [7:0] SQP_R_PORT = 8'h00;
  localparam logic [7:0] SQP_R_PRIO = 8'h00;
  localparam logic [7:0] SQP_R_RSV = 8'h00;
  localparam logic [8:0] SQP_R_MCAP = 9'h0FF;
  localparam logic [8:0] SQP_R_LTHR = 9'h018;
  localparam logic [3:0] SQP_TRK0 = 4'h0;
  localparam logic [3:0] SQP_TRK1 = 4'h1;
endpackage

/* sqp_sched.sv */
// sqp_sched: per-destination pick between high and low queue.
// assumes take_i is a one-cycle pulse from the transmit mac.
`timescale 1ns/100ps
`default_nettype none
module sqp_sched
  import sqp_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // queue state and request
  input wire logic hi_rdy_i,
  input wire logic lo_rdy_i,
  input wire logic take_i,
  input wire logic qos_i,
  input wire logic [3:0] weight_i,
  // pick, one-cycle pulses
  output logic sel_hi_o,
  output logic sel_lo_o,
  output logic sel_fifo_o
);
  logic [3:0] cnt_q;
  logic [3:0] w;

  // weight 0 is treated as 1 so high traffic never starves
  assign w = (weight_i == 4'h0) ? 4'h1 : weight_i;

  // weighted round robin, or plain arrival order when qos is off
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cnt_q <= 4'h0;
      sel_hi_o <= 1'b0;
      sel_lo_o <= 1'b0;
      sel_fifo_o <= 1'b0;
    end else begin
      sel_hi_o <= 1'b0;
      sel_lo_o <= 1'b0;
      sel_fifo_o <= 1'b0;
      if (take_i) begin
        if (!qos_i) begin
          sel_fifo_o <= hi_rdy_i | lo_rdy_i;
          cnt_q <= 4'h0;
        end else if (hi_rdy_i && lo_rdy_i) begin
          if (cnt_q >= w) begin
            sel_lo_o <= 1'b1;
            cnt_q <= 4'h0;
          end else begin
            sel_hi_o <= 1'b1;
            cnt_q <= cnt_q + 4'h1;
          end
        end else if (hi_rdy_i) begin
          sel_hi_o <= 1'b1;
        end else if (lo_rdy_i) begin
          sel_lo_o <= 1'b1;
          cnt_q <= 4'h0;
        end
      end
    end
  end

  property p_fifo_only;
    @(posedge core_clk_i) disable iff (!nrst_i)
    take_i && !qos_i |=> !sel_hi_o && !sel_lo_o;
  endproperty
  a_fifo_only: assert property (p_fifo_only)
    else $error("priority pick while qos off");

  property p_wrr_low;
    @(posedge core_clk_i) disable iff (!nrst_i)
    take_i && qos_i && hi_rdy_i && lo_rdy_i && cnt_q >= w |=> sel_lo_o;
  endproperty
  a_wrr_low: assert property (p_wrr_low)
    else $error("low packet not sent after weight");

  c_wrr: cover property (@(posedge core_clk_i) sel_lo_o && $past(cnt_q) > 1);
endmodule
`default_nettype wire

/* sqp_policy.sv */
// sqp_policy: forwarding policy of a nine-port layer 2 switch.
// assumes mac-side requests are single-cycle pulses on core_clk_i;
// strap and link pins arrive asynchronously and are synchronised here.
`timescale 1ns/100ps
`default_nettype none
module sqp_policy
  import sqp_pkg::*;
#(
  parameter int NPORT = SQP_NPORT
)(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // straps and link status pins
  input wire logic trunk_en_i,
  input wire logic big_mem_i,
  input wire logic [1:0] link_up_i,
  // buffer admission and release
  input wire logic adm_req_i,
  input wire logic [3:0] adm_src_i,
  input wire logic adm_mcast_i,
  input wire logic adm_lowdrop_i,
  input wire logic adm_map_hi_i,
  input wire logic rel_i,
  input wire logic rel_mcast_i,
  output logic adm_ok_o,
  output logic adm_drop_o,
  output logic adm_fc_o,
  output logic adm_wred_o,
  output logic adm_hi_o,
  // vlan forwarding lookup
  input wire logic fwd_req_i,
  input wire logic [3:0] fwd_src_i,
  input wire logic [NPORT-1:0] fwd_mask_i,
  output logic [NPORT-1:0] fwd_mask_o,
  // trunk egress and learning check
  input wire logic trk_req_i,
  input wire logic [3:0] trk_dst_i,
  input wire logic sa_lsb_i,
  input wire logic da_lsb_i,
  output logic [3:0] trk_port_o,
  input wire logic lrn_req_i,
  input wire logic [3:0] lrn_src_i,
  input wire logic [3:0] lrn_port_i,
  output logic relearn_o,
  // transmit queue pick per destination
  input wire logic [NPORT-1:0] q_hi_rdy_i,
  input wire logic [NPORT-1:0] q_lo_rdy_i,
  input wire logic [NPORT-1:0] q_take_i,
  output logic [NPORT-1:0] q_sel_hi_o,
  output logic [NPORT-1:0] q_sel_lo_o,
  output logic [NPORT-1:0] q_sel_fifo_o
);
  logic [7:0] sched_q;
  logic [7:0] prio_q;
  logic [7:0] rsv_q;
  logic [8:0] mcap_q;
  logic [8:0] lthr_q;
  logic [7:0] pctl_q [NPORT];
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [8:0] cap_q;
  logic [8:0] used_q;
  logic [8:0] mused_q;
  logic wait_q;
  logic trunk;
  logic [1:0] link;
  logic [8:0] free;
  logic shared_ok;
  logic congested;
  logic admit;
  logic src_fc;
  logic acc;
  logic [31:0] rdata;

  // the first stage feeds only the second stage
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {link_up_i, big_mem_i, trunk_en_i};
      sync2_q <= sync1_q;
    end
  end
  assign trunk = sync2_q[0];
  assign link = sync2_q[3:2];

  // capacity follows the memory-size strap
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cap_q <= SQP_CAP_SMALL;
    end else begin
      cap_q <= sync2_q[1] ? SQP_CAP_BIG : SQP_CAP_SMALL;
    end
  end

  // avalon: one wait cycle, then the access completes
  assign acc = (avs_read_i || avs_write_i) && !wait_q;
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((avs_read_i || avs_write_i) && wait_q);
    end
  end
  assign avs_waitrequest_o = wait_q;

  // register writes; port control words follow the status word
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      sched_q <= SQP_R_SCHED;
      prio_q <= SQP_R_PRIO;
      rsv_q <= SQP_R_RSV;
      mcap_q <= SQP_R_MCAP;
      lthr_q <= SQP_R_LTHR;
      for (int i = 0; i < NPORT; i++) begin
        pctl_q[i] <= SQP_R_PORT;
      end
    end else if (acc && avs_write_i) begin
      case (avs_address_i)
        SQP_A_SCHED: sched_q <= avs_writedata_i[7:0];
        SQP_A_PRIO: prio_q <= avs_writedata_i[7:0];
        SQP_A_RSV: rsv_q <= avs_writedata_i[7:0];
        SQP_A_MCAP: mcap_q <= avs_writedata_i[8:0];
        SQP_A_LTHR: lthr_q <= avs_writedata_i[8:0];
        default: begin
          for (int i = 0; i < NPORT; i++) begin
            if (avs_address_i == SQP_A_PORT0 + 4'(i)) begin
              pctl_q[i] <= avs_writedata_i[7:0];
            end
          end
        end
      endcase
    end
  end

  // read mux; unmapped words read zero
  always_comb begin
    rdata = 32'h0;
    case (avs_address_i)
      SQP_A_SCHED: rdata[7:0] = sched_q;
      SQP_A_PRIO: rdata[7:0] = prio_q;
      SQP_A_RSV: rdata[7:0] = rsv_q;
      SQP_A_MCAP: rdata[8:0] = mcap_q;
      SQP_A_LTHR: rdata[8:0] = lthr_q;
      SQP_A_STAT: rdata = {4'h0, link, trunk, congested, 6'h0,
                           mused_q, used_q};
      default: begin
        for (int i = 0; i < NPORT; i++) begin
          if (avs_address_i == SQP_A_PORT0 + 4'(i)) begin
            rdata[7:0] = pctl_q[i];
          end
        end
      end
    endcase
  end

  // read data is sampled in the wait cycle so it stands at completion
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      avs_readdata_o <= 32'h0;
    end else if (avs_read_i && wait_q) begin
      avs_readdata_o <= rdata;
    end
  end

  // admission: shared pool first, reserve only for low-drop unicast
  assign free = cap_q - used_q;
  assign shared_ok = free > {1'b0, rsv_q};
  assign congested = free < lthr_q;
  assign admit = adm_req_i && (free != 9'h0) &&
    (shared_ok || (adm_lowdrop_i && !adm_mcast_i)) &&
    !(adm_mcast_i && mused_q >= mcap_q);
  assign src_fc = pctl_q[adm_src_i][SQP_B_FCEN] && !sched_q[SQP_B_FCDIS];

  // occupancy counters; an admit and a release together cancel out
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      used_q <= 9'h0;
      mused_q <= 9'h0;
    end else begin
      if (admit && !(rel_i && used_q != 9'h0)) begin
        used_q <= used_q + 9'h1;
      end else if (!admit && rel_i && used_q != 9'h0) begin
        used_q <= used_q - 9'h1;
      end
      if (admit && adm_mcast_i && !(rel_i && rel_mcast_i)) begin
        mused_q <= mused_q + 9'h1;
      end else if (!(admit && adm_mcast_i) && rel_i && rel_mcast_i &&
                   mused_q != 9'h0) begin
        mused_q <= mused_q - 9'h1;
      end
    end
  end

  // per-packet verdict, congestion reaction and priority
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      adm_ok_o <= 1'b0;
      adm_drop_o <= 1'b0;
      adm_fc_o <= 1'b0;
      adm_wred_o <= 1'b0;
      adm_hi_o <= 1'b0;
    end else begin
      adm_ok_o <= admit;
      adm_drop_o <= adm_req_i && !admit;
      adm_fc_o <= adm_req_i && congested && src_fc;
      adm_wred_o <= adm_req_i && congested && !src_fc;
      if (adm_src_i < 4'(SQP_NPRI) && prio_q[2*adm_src_i]) begin
        adm_hi_o <= prio_q[2*adm_src_i+1];
      end else begin
        adm_hi_o <= adm_map_hi_i;
      end
    end
  end

  // vlan membership: same id as source, never back to the source
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      fwd_mask_o <= '0;
    end else if (fwd_req_i) begin
      for (int i = 0; i < NPORT; i++) begin
        fwd_mask_o[i] <= fwd_mask_i[i] && 4'(i) != fwd_src_i &&
          pctl_q[i][SQP_B_VHI:SQP_B_VLO] ==
          pctl_q[fwd_src_i][SQP_B_VHI:SQP_B_VLO];
      end
    end
  end

  // trunk member pick: hash, overridden by a dead link
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      trk_port_o <= SQP_TRK0;
    end else if (trk_req_i) begin
      if (trunk && (trk_dst_i == SQP_TRK0 || trk_dst_i == SQP_TRK1)) begin
        if (!link[0] && link[1]) begin
          trk_port_o <= SQP_TRK1;
        end else if (!link[1] && link[0]) begin
          trk_port_o <= SQP_TRK0;
        end else begin
          trk_port_o <= (sa_lsb_i ^ da_lsb_i) ? SQP_TRK1 : SQP_TRK0;
        end
      end else begin
        trk_port_o <= trk_dst_i;
      end
    end
  end

  // relearn a trunk source whose entry points outside the trunk
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      relearn_o <= 1'b0;
    end else begin
      relearn_o <= lrn_req_i && trunk &&
        (lrn_src_i == SQP_TRK0 || lrn_src_i == SQP_TRK1) &&
        lrn_port_i != SQP_TRK0 && lrn_port_i != SQP_TRK1;
    end
  end

  // qos per destination: global on, and full duplex or half allowed
  for (genvar g = 0; g < NPORT; g++) begin : g_sch
    logic qos;
    assign qos = sched_q[SQP_B_QOS] &&
      (!pctl_q[g][SQP_B_HDX] || sched_q[SQP_B_HDXQ]);
    sqp_sched u_sch (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .hi_rdy_i(q_hi_rdy_i[g]),
      .lo_rdy_i(q_lo_rdy_i[g]),
      .take_i(q_take_i[g]),
      .qos_i(qos),
      .weight_i(sched_q[SQP_B_WHI:SQP_B_WLO]),
      .sel_hi_o(q_sel_hi_o[g]),
      .sel_lo_o(q_sel_lo_o[g]),
      .sel_fifo_o(q_sel_fifo_o[g])
    );
  end

  property p_fc_gdis;
    @(posedge core_clk_i) disable iff (!nrst_i)
    adm_req_i && sched_q[SQP_B_FCDIS] |=> !adm_fc_o;
  endproperty
  a_fc_gdis: assert property (p_fc_gdis)
    else $error("flow control while globally off");

  property p_fc_src;
    @(posedge core_clk_i) disable iff (!nrst_i)
    adm_req_i && congested && src_fc |=> adm_fc_o && !adm_wred_o;
  endproperty
  a_fc_src: assert property (p_fc_src)
    else $error("no flow control for enabled source");

  property p_wred;
    @(posedge core_clk_i) disable iff (!nrst_i)
    adm_req_i && congested && !src_fc |=> adm_wred_o && !adm_fc_o;
  endproperty
  a_wred: assert property (p_wred)
    else $error("no wred for disabled source");

  property p_ovr;
    @(posedge core_clk_i) disable iff (!nrst_i)
    adm_req_i && adm_src_i == 4'h2 && prio_q[4]
      |=> adm_hi_o == $past(prio_q[5]);
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("override priority not applied");

  property p_rsv;
    @(posedge core_clk_i) disable iff (!nrst_i)
    adm_req_i && !shared_ok && (adm_mcast_i || !adm_lowdrop_i)
      |=> adm_drop_o;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserve used by other traffic");

  property p_cap;
    @(posedge core_clk_i) disable iff (!nrst_i)
    used_q <= cap_q || $past(cap_q) != cap_q;
  endproperty
  a_cap: assert property (p_cap)
    else $error("buffer count above capacity");

  property p_fail;
    @(posedge core_clk_i) disable iff (!nrst_i)
    trk_req_i && trunk && trk_dst_i == SQP_TRK0 && link == 2'b10
      |=> trk_port_o == SQP_TRK1;
  endproperty
  a_fail: assert property (p_fail)
    else $error("trunk traffic on dead member");

  property p_hash;
    @(posedge core_clk_i) disable iff (!nrst_i)
    trk_req_i && trunk && trk_dst_i == SQP_TRK1 && link == 2'b11
      |=> trk_port_o[0] == $past(sa_lsb_i ^ da_lsb_i);
  endproperty
  a_hash: assert property (p_hash)
    else $error("trunk hash mismatch");

  property p_relearn;
    @(posedge core_clk_i) disable iff (!nrst_i)
    lrn_req_i && !trunk |=> !relearn_o;
  endproperty
  a_relearn: assert property (p_relearn)
    else $error("relearn without trunk");

  c_fc: cover property (@(posedge core_clk_i) adm_fc_o);
  c_drop: cover property (@(posedge core_clk_i) adm_drop_o && adm_wred_o);
  c_fail: cover property (@(posedge core_clk_i) trk_req_i && link == 2'b01);
endmodule
`default_nettype wire

/* sqp_mac_model.sv */
// sqp_mac_model: transmit mac and phy link pins facing sqp_policy.
// assumes one destination port is exercised at a time by the bench.
`timescale 1ns/100ps
`default_nettype none
module sqp_mac_model
  import sqp_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // bench commands
  input wire logic [3:0] port_i,
  input wire logic load_i,
  input wire logic [7:0] n_run_i,
  input wire logic [1:0] link_i,
  // scheduler side
  input wire logic [8:0] sel_hi_i,
  input wire logic [8:0] sel_lo_i,
  input wire logic [8:0] sel_fifo_i,
  output logic [8:0] take_o,
  output logic [8:0] hi_rdy_o,
  output logic [8:0] lo_rdy_o,
  // link pins and tallies
  output logic [1:0] link_up_o,
  output logic [7:0] n_hi_o,
  output logic [7:0] n_lo_o,
  output logic [7:0] n_fifo_o,
  output logic busy_o
);
  logic [7:0] hq_q, lq_q, left_q;
  logic wait_q;
  logic h, l, f;
  // queues start deep so neither runs dry within one run
  assign hi_rdy_o = {8'h00, hq_q != 8'h00} << port_i;
  assign lo_rdy_o = {8'h00, lq_q != 8'h00} << port_i;
  assign busy_o = (left_q != 8'h00) || wait_q || (take_o != 9'h000);
  assign h = sel_hi_i[port_i];
  assign l = sel_lo_i[port_i];
  assign f = sel_fifo_i[port_i];
  // link status changes on a clock edge, like a phy status pin
  always_ff @(posedge core_clk_i) begin
    link_up_o <= nrst_i ? link_i : 2'h3;
  end
  // one take, then a cycle for the pick, so takes never overlap
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || load_i) begin
      hq_q <= 8'h64;
      lq_q <= 8'h64;
      left_q <= load_i ? n_run_i : 8'h00;
      n_hi_o <= 8'h00;
      n_lo_o <= 8'h00;
      n_fifo_o <= 8'h00;
      take_o <= 9'h000;
      wait_q <= 1'b0;
    end else if (take_o != 9'h000) begin
      take_o <= 9'h000;
      wait_q <= 1'b1;
    end else if (wait_q) begin
      wait_q <= 1'b0;
      hq_q <= hq_q - {7'h00, h | f};
      lq_q <= lq_q - {7'h00, l};
      n_hi_o <= n_hi_o + {7'h00, h};
      n_lo_o <= n_lo_o + {7'h00, l};
      n_fifo_o <= n_fifo_o + {7'h00, f};
    end else if (left_q != 8'h00) begin
      take_o <= 9'h001 << port_i;
      left_q <= left_q - 8'h01;
    end
  end
endmodule
`default_nettype wire

/* sqp_policy_bench.sv */
// sqp_policy_bench: self-checking bench for sqp_policy.
// assumes sqp_mac_model on the queue side and a 20 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module sqp_policy_bench
  import sqp_pkg::*;
;
  logic clk, nrst, rd, wr, trk_en, adm_req, adm_mc, adm_ld, adm_map;
  logic rel, rel_mc, lk_req, sa, da, load, wreq, busy, big;
  logic ok, drop, fc, wred, hi, rlrn;
  logic [3:0] adr, adm_src, src, dst, lport, mport, tport;
  logic [31:0] wdata, rdata, rdout;
  logic [8:0] mask, fmask, take, hrdy, lrdy, s_hi, s_lo, s_fifo;
  logic [7:0] n_run, nh, nl, nf;
  logic [1:0] link, lup;
  logic [2:0] vl [9];
  int failures, n_compared;
  logic [3:0] ra [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'hE, 4'hF};
  logic [31:0] re [8] = '{32'h4, 32'h0, 32'h0, 32'hFF, 32'h18, 32'h0,
    32'h0, 32'h0};
  logic [31:0] sv [4] = '{32'h04, 32'h24, 32'h44, 32'h64};
  logic [31:0] qs [6] = '{32'h00, 32'h20, 32'h20, 32'hA0, 32'hA0, 32'h80};
  logic [3:0] qp [6] = '{4'h4, 4'h4, 4'h5, 4'h5, 4'h4, 4'h5};
  logic [2:0] tl [4] = '{3'h3, 3'h7, 3'h5, 3'h6};

  sqp_policy u_dut (.core_clk_i(clk), .nrst_i(nrst), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_readdata_o(rdout), .avs_waitrequest_o(wreq),
    .trunk_en_i(trk_en), .big_mem_i(big), .link_up_i(lup),
    .adm_req_i(adm_req), .adm_src_i(adm_src), .adm_mcast_i(adm_mc),
    .adm_lowdrop_i(adm_ld), .adm_map_hi_i(adm_map), .rel_i(rel),
    .rel_mcast_i(rel_mc), .adm_ok_o(ok), .adm_drop_o(drop), .adm_fc_o(fc),
    .adm_wred_o(wred), .adm_hi_o(hi), .fwd_req_i(lk_req), .fwd_src_i(src),
    .fwd_mask_i(mask), .fwd_mask_o(fmask), .trk_req_i(lk_req),
    .trk_dst_i(dst), .sa_lsb_i(sa), .da_lsb_i(da), .trk_port_o(tport),
    .lrn_req_i(lk_req), .lrn_src_i(src), .lrn_port_i(lport),
    .relearn_o(rlrn), .q_hi_rdy_i(hrdy), .q_lo_rdy_i(lrdy),
    .q_take_i(take), .q_sel_hi_o(s_hi), .q_sel_lo_o(s_lo),
    .q_sel_fifo_o(s_fifo));
  sqp_mac_model u_mac (.core_clk_i(clk), .nrst_i(nrst), .port_i(mport),
    .load_i(load), .n_run_i(n_run), .link_i(link), .sel_hi_i(s_hi),
    .sel_lo_i(s_lo), .sel_fifo_i(s_fifo), .take_o(take), .hi_rdy_o(hrdy),
    .lo_rdy_o(lrdy), .link_up_o(lup), .n_hi_o(nh), .n_lo_o(nl),
    .n_fifo_o(nf), .busy_o(busy));

  // 20 MHz clock
  always #25 clk = ~clk;

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wrap_up;
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task tmo;
    failures++;
    wrap_up();
  endtask
  // one avalon access; the request stands until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    rdata = rdout;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wreq !== 1'b0)
      tmo();
  endtask
  // admission request; verdict is read one cycle after the pulse
  task adm(input logic [3:0] s, input logic m, l, p);
    @(posedge clk);
    adm_req <= 1'b1;
    adm_src <= s;
    adm_mc <= m;
    adm_ld <= l;
    adm_map <= p;
    @(posedge clk);
    adm_req <= 1'b0;
    @(posedge clk);
  endtask
  task rls(input int n, input logic m);
    @(posedge clk);
    rel <= 1'b1;
    rel_mc <= m;
    repeat (n) @(posedge clk);
    rel <= 1'b0;
  endtask
  // vlan, trunk and learning lookups share one request pulse
  task lk(input logic [3:0] s, d, l, input logic [31:0] r);
    @(posedge clk);
    lk_req <= 1'b1;
    src <= s;
    dst <= d;
    lport <= l;
    mask <= r[8:0];
    sa <= r[9];
    da <= r[10];
    @(posedge clk);
    lk_req <= 1'b0;
    @(posedge clk);
  endtask
  task run(input logic [3:0] p, input logic [7:0] k);
    int n;
    @(posedge clk);
    mport <= p;
    n_run <= k;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busy && n < 200);
    if (busy !== 1'b0)
      tmo();
  endtask
  function automatic logic [8:0] fexp(logic [3:0] s, logic [8:0] m);
    fexp = '0;
    for (int p = 0; p < 9; p++)
      fexp[p] = m[p] && vl[p] == vl[s] && p != s;
  endfunction
  function automatic logic [3:0] texp(logic [3:0] d);
    if (!trk_en || d > 4'h1)
      return d;
    if (link != 2'b11)
      return {3'h0, link == 2'b10};
    return {3'h0, sa ^ da};
  endfunction

  // main sequence
  initial begin
    int u, t;
    logic [3:0] w;
    logic x, q;
    logic [31:0] e;
    clk = 1'b0;
    {nrst, rd, wr, trk_en, adm_req, adm_mc, adm_ld, adm_map} = '0;
    {rel, rel_mc, lk_req, sa, da, load, big} = '0;
    {adr, adm_src, src, dst, lport, mport, n_run, wdata, mask} = '0;
    link = 2'h3;
    failures = 0;
    n_compared = 0;
    u = $urandom(32'h3E287C02);
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    // reset values; the unmapped word ignores writes
    bus(1'b1, 4'hF, 32'hFFFFFFFF);
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0);
      chk(rdata, re[i]);
    end
    // ports 1 and 2 forced low and high, the rest keep the mapping
    bus(1'b1, SQP_A_PRIO, 32'h34);
    repeat (12) begin
      u = $urandom_range(8);
      w = 4'($urandom);
      adm(4'(u), 1'b0, 1'b0, w[0]);
      e = u == 1 ? 32'h0 : u == 2 ? 32'h1 : 32'(w[0]);
      chk(32'(hi), e);
    end
    rls(12, 1'b0);
    // multicast bounded at two
    bus(1'b1, SQP_A_MCAP, 32'h2);
    for (u = 0; u < 3; u++) begin
      adm(4'h2, 1'b1, 1'b0, 1'b0);
      chk(32'({ok, drop}), u < 2 ? 32'h2 : 32'h1);
    end
    rls(2, 1'b1);
    // fill to the brim: shared pool, then the low-drop reserve
    bus(1'b1, SQP_A_PORT0, 32'h1);
    bus(1'b1, SQP_A_RSV, 32'hA);
    bus(1'b1, SQP_A_LTHR, 32'h14);
    for (u = 0; u < 172; u++) begin
      t = u > 160 ? u - 1 : u;
      x = u > 160 ? t < 170 : t < 160;
      adm(4'h1, 1'b0, u > 160, 1'b0);
      e = 32'({x, !x, 1'b0, t > 150});
      chk(32'({ok, drop, fc, wred}), e);
    end
    // congested source with flow control, under every qos mix
    foreach (sv[i]) begin
      bus(1'b1, SQP_A_SCHED, sv[i]);
      adm(4'h0, 1'b0, 1'b0, 1'b0);
      e = sv[i][6] ? 32'h5 : 32'h6;
      chk(32'({drop, fc, wred}), e);
    end
    rls(170, 1'b0);
    // capacity strap seen through the status word: 340 free is not below
    // a threshold of 340, 170 free is
    bus(1'b1, SQP_A_LTHR, 32'h154);
    for (t = 0; t < 2; t++) begin
      big <= t[0];
      repeat (5) @(posedge clk);
      bus(1'b0, SQP_A_STAT, 32'h0);
      e = t[0] ? 32'h0C000000 : 32'h0D000000;
      chk(rdata, e);
    end
    // queue picks: port 4 full duplex, port 5 half duplex
    w = 4'($urandom_range(15, 1));
    bus(1'b1, SQP_A_PORT0 + 4'h5, 32'h2);
    foreach (qs[i]) begin
      bus(1'b1, SQP_A_SCHED, qs[i] | 32'(w));
      run(qp[i], 8'(3 * w + 3));
      q = qs[i][5] && (qp[i] == 4'h4 || qs[i][7]);
      e = q ? {8'h0, 8'(3 * w), 8'h3, 8'h0} : {16'h0, 8'(3 * w + 3)};
      chk(32'({nh, nl, nf}), e);
    end
    // vlan ids, then trunk straps and link states
    foreach (vl[i]) begin
      vl[i] = 3'($urandom_range(7));
      bus(1'b1, SQP_A_PORT0 + 4'(i), 32'(vl[i]) << 4);
    end
    foreach (tl[i]) begin
      trk_en <= tl[i][2];
      link <= tl[i][1:0];
      repeat (5) @(posedge clk);
      // the first two lookups aim at the trunk members on purpose
      for (t = 0; t < 10; t++) begin
        lk(4'(t < 2 ? t : $urandom_range(8)),
          4'(t < 2 ? t : $urandom_range(8)),
          4'($urandom_range(8)), $urandom);
        if (!trk_en)
          chk(32'(fmask), 32'(fexp(src, mask)));
        chk(32'(tport), 32'(texp(dst)));
        chk(32'(rlrn), 32'(trk_en && src < 2 && lport > 1));
      end
    end
    wrap_up();
  end
endmodule
`default_nettype wire
